// ### ixm_dev.sv
// Index memory end: 64 two-core words, buffer register and cycle timing
`timescale 1ns/1ps
`include "ixm_consts.svh"
module ixm_dev (
   input  wire logic core_clk_in,
   input  wire logic rst_b_in,
   output logic      busy_out,
   output logic      parity_ok_out,
   ixm_if.dev        mem
);
   import ixm_pkg::*;

   typedef enum logic [1:0] {
      IXM_D_IDLE,
      IXM_D_ACCESS,
      IXM_D_WRITE,
      IXM_D_RECOVER
   } ixm_dst_t;

   // Strobe to end of recovery. Two cycles go to the write slot and to
   // the return to idle, and the access wait of the next cycle makes up
   // the rest, so a controller that starts at once strobes a cycle later.
   // Limitation: the core does not refuse a faster controller; keeping
   // the spacing is the controller's part, this count only holds busy.
   localparam logic [`IXM_CNT_W-1:0] REC_LAST =
      `IXM_CNT_W'(`IXM_CYCLE_CYC - `IXM_ACCESS_CYC - 2);

   // One-hot pair line from the low address field
   // Only one line is ever hot, so one pair sees the drive currents
   function automatic logic [`IXM_PAIRS-1:0] pair_line(
      input logic [`IXM_LINE_W-1:0] sel);
      logic [`IXM_PAIRS-1:0] hot;
      hot      = '0;
      hot[sel] = 1'b1;
      return hot;
   endfunction

   // Even parity over the word, parity bit included
   function automatic logic word_parity_ok(input ixm_word_t w);
      return ~^w;
   endfunction

   // A bit with both cores set is a word written twice without a clear;
   // it reads as a one, so parity alone may miss it
   function automatic logic cores_clean(input ixm_word_t a,
                                        input ixm_word_t b);
      return ~|(a & b);
   endfunction

   ixm_dst_t               state_r;
   ixm_cyc_t               kind_r;
   logic                   half_r;
   logic [`IXM_PAIRS-1:0]  line_r;
   logic [`IXM_LINE_W-1:0] line_idx_r;
   logic [`IXM_CNT_W-1:0]  cnt_r;
   ixm_word_t              buf_r;
   logic                   rd_pulse;
   logic                   wr_pulse;
   ixm_word_t              sense;
   ixm_word_t              sense_b;
   logic [`IXM_LINE_W-1:0] addr_line;
   logic                   addr_half;

   // Two cores per bit: A set means one, B set means zero
   // Kept as two planes so that a double set stays visible
   ixm_word_t core_a_r [2][`IXM_PAIRS];
   ixm_word_t core_b_r [2][`IXM_PAIRS];

   // Read pulse on the strobe in the access phase; write one cycle later
   assign rd_pulse = (state_r == IXM_D_ACCESS) && mem.strobe;
   assign wr_pulse = (state_r == IXM_D_WRITE);

   // Sense: only an A core reads a one; a bare word reads as zero
   assign sense = core_a_r[half_r][line_idx_r];

   // B cores of the same word, read only to spot a double set
   assign sense_b = core_b_r[half_r][line_idx_r];

   // Address fields split once for the decoder and the half select
   assign addr_line = mem.addr[`IXM_LINE_W-1:0];
   assign addr_half = mem.addr[`IXM_HALF_BIT];

   // Cycle sequencer
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r    <= IXM_D_IDLE;
         kind_r     <= IXM_CYC_RW;
         half_r     <= 1'b0;
         line_r     <= '0;
         line_idx_r <= '0;
         cnt_r      <= '0;
      end else begin
         unique case (state_r)
            IXM_D_IDLE: begin
               // Latch kind and address so the link may move on
               if (mem.start) begin
                  kind_r     <= mem.cyc_type;
                  line_r     <= pair_line(addr_line);
                  line_idx_r <= addr_line;
                  half_r     <= addr_half;
                  state_r    <= IXM_D_ACCESS;
               end
            end
            IXM_D_ACCESS: begin
               // Read-only ends after recovery with no write
               // A strobe outside this state is ignored
               if (mem.strobe) begin
                  cnt_r   <= '0;
                  state_r <= (kind_r == IXM_CYC_RO) ? IXM_D_RECOVER
                                                   : IXM_D_WRITE;
               end
            end
            IXM_D_WRITE: begin
               // One write slot: restore or new word from the buffer
               cnt_r   <= cnt_r + `IXM_CNT_W'(1);
               state_r <= IXM_D_RECOVER;
            end
            IXM_D_RECOVER: begin
               // Fixes strobe-to-strobe spacing of a repeated cycle
               // Read-only spends its write slot here, so all kinds match
               if (cnt_r >= REC_LAST) begin
                  state_r <= IXM_D_IDLE;
               end else begin
                  cnt_r <= cnt_r + `IXM_CNT_W'(1);
               end
            end
         endcase
      end
   end

   // Done: one-cycle pulse as recovery ends
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mem.done <= 1'b0;
      end else begin
         mem.done <= (state_r == IXM_D_RECOVER) && (cnt_r >= REC_LAST);
      end
   end

   // Busy: from the start pulse onward, cleared the cycle after idle,
   // so the controller cannot slip a second start into a running cycle
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mem.busy <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         mem.busy <= (state_r != IXM_D_IDLE) || mem.start;
         busy_out <= (state_r != IXM_D_IDLE) || mem.start;
      end
   end

   // Buffer register: strobe jams the sensed value, prior state ignored
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         buf_r         <= '0;
         mem.buf_q     <= '0;
         parity_ok_out <= 1'b0;
      end else begin
         // Clear-write skips the strobe so the buffer survives
         if (rd_pulse && (kind_r != IXM_CYC_CW)) begin
            buf_r         <= sense;
            mem.buf_q     <= sense;
            // Flag also drops for a doubly set bit
            parity_ok_out <= word_parity_ok(sense) &&
                             cores_clean(sense, sense_b);
         // Controller load, at any time but a non-clear-write strobe, which wins
         end else if (mem.buf_load) begin
            buf_r     <= mem.buf_wdata;
            mem.buf_q <= mem.buf_wdata;
         end
      end
   end

   // Core planes, one process per word: two per pair line, one per half
   // A cleared word has neither core of any bit set
   for (genvar p = 0; p < `IXM_PAIRS; p++) begin : g_pair
      for (genvar h = 0; h < 2; h++) begin : g_half
         always_ff @(posedge core_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               core_a_r[h][p] <= '0;
               core_b_r[h][p] <= '0;
            end else if (line_r[p] && (half_r == 1'(h))) begin
               if (rd_pulse) begin
                  // Destructive read: both cores end cleared
                  core_a_r[h][p] <= '0;
                  core_b_r[h][p] <= '0;
               end else if (wr_pulse) begin
                  // Bias current sets A for ones, B for zeros
                  // Restore of a read-write comes from buffer
                  // Sets accumulate: a second write can set both
                  core_a_r[h][p] <= core_a_r[h][p] | buf_r;
                  core_b_r[h][p] <= core_b_r[h][p] | ~buf_r;
               end
            end
         end
      end
   end
endmodule

// ### ixm_consts.svh
// Constants for the index memory: geometry, address fields and timing
`ifndef IXM_CONSTS_SVH
`define IXM_CONSTS_SVH

`define IXM_WORDS        64
`define IXM_WIDTH        19
`define IXM_PARITY_BIT   18
`define IXM_ADDR_W       6
`define IXM_PAIRS        32
`define IXM_LINE_W       5
`define IXM_HALF_BIT     5
`define IXM_CLK_NS       40
`define IXM_CYCLE_NS     3600
`define IXM_ACCESS_NS    600
// Cycle time is a longest spacing: round down; access is a least: round up
`define IXM_CYCLE_CYC    (`IXM_CYCLE_NS / `IXM_CLK_NS)
`define IXM_ACCESS_CYC   ((`IXM_ACCESS_NS + `IXM_CLK_NS - 1) / `IXM_CLK_NS)
`define IXM_CNT_W        7

`endif

// ### ixm_pkg.sv
// Types shared by both ends of the index memory link
package ixm_pkg;
   typedef enum logic [1:0] {
      IXM_CYC_RW = 2'h0,
      IXM_CYC_RO = 2'h1,
      IXM_CYC_CW = 2'h2
   } ixm_cyc_t;
   typedef logic [18:0] ixm_word_t;
   typedef logic [5:0]  ixm_addr_t;
endpackage

// ### ixm_if.sv
// Link between the index memory and its control sequencer
`timescale 1ns/1ps
interface ixm_if;
   import ixm_pkg::*;
   ixm_addr_t addr;
   ixm_cyc_t  cyc_type;
   logic      start;
   logic      strobe;
   logic      buf_load;
   ixm_word_t buf_wdata;
   ixm_word_t buf_q;
   logic      busy;
   logic      done;

   modport dev (input addr, cyc_type, start, strobe, buf_load, buf_wdata,
                output buf_q, busy, done);
   modport ctl (output addr, cyc_type, start, strobe, buf_load, buf_wdata,
                input buf_q, busy, done);
endinterface

// ### ixm_ctl.sv
// Control sequencer end: issues cycles, address timing and strobes
`timescale 1ns/1ps
`include "ixm_consts.svh"
module ixm_ctl (
   input  wire logic            core_clk_in,
   input  wire logic            rst_b_in,
   input  wire logic            req_in,
   input  wire ixm_pkg::ixm_cyc_t req_type_in,
   input  wire ixm_pkg::ixm_addr_t req_addr_in,
   input  wire ixm_pkg::ixm_word_t wr_data_in,
   output logic                 ready_out,
   output logic                 done_out,
   output ixm_pkg::ixm_word_t   rd_data_out,
   ixm_if.ctl                   mem
);
   import ixm_pkg::*;

   typedef enum logic [1:0] {IXM_C_IDLE, IXM_C_ACCESS, IXM_C_WAIT} ixm_cst_t;

   localparam logic [`IXM_CNT_W-1:0] ACC_LAST =
      `IXM_CNT_W'(`IXM_ACCESS_CYC - 1);

   ixm_cst_t               state_r;
   logic [`IXM_CNT_W-1:0]  cnt_r;

   // Sequencer: load address, hold off the strobe, then wait for the end
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r       <= IXM_C_IDLE;
         cnt_r         <= '0;
         mem.addr      <= '0;
         mem.cyc_type  <= IXM_CYC_RW;
         mem.start     <= 1'b0;
         mem.strobe    <= 1'b0;
         mem.buf_load  <= 1'b0;
         mem.buf_wdata <= '0;
         ready_out     <= 1'b1;
         done_out      <= 1'b0;
         rd_data_out   <= '0;
      end else begin
         mem.start    <= 1'b0;
         mem.strobe   <= 1'b0;
         mem.buf_load <= 1'b0;
         done_out     <= 1'b0;
         unique case (state_r)
            IXM_C_IDLE: begin
               if (req_in && !mem.busy) begin
                  mem.addr     <= req_addr_in;
                  mem.cyc_type <= req_type_in;
                  mem.start    <= 1'b1;
                  // Only cleared-then-written cycles load the buffer here
                  mem.buf_load  <= (req_type_in == IXM_CYC_CW);
                  mem.buf_wdata <= wr_data_in;
                  ready_out     <= 1'b0;
                  cnt_r         <= '0;
                  state_r       <= IXM_C_ACCESS;
               end
            end
            IXM_C_ACCESS: begin
               // Strobe no sooner than access time after address
               if (cnt_r == ACC_LAST) begin
                  mem.strobe <= 1'b1;
                  state_r    <= IXM_C_WAIT;
               end else begin
                  cnt_r <= cnt_r + `IXM_CNT_W'(1);
               end
            end
            IXM_C_WAIT: begin
               if (mem.done) begin
                  rd_data_out <= mem.buf_q;
                  done_out    <= 1'b1;
                  ready_out   <= 1'b1;
                  state_r     <= IXM_C_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// ### ixm_assertions.sv
// Checker on the link between the index memory and its sequencer
`timescale 1ns/1ps
module ixm_assertions (
   input wire logic               core_clk_in,
   input wire logic               rst_b_in,
   input wire ixm_pkg::ixm_addr_t addr,
   input wire ixm_pkg::ixm_cyc_t  cyc_type,
   input wire logic               start,
   input wire logic               strobe,
   input wire logic               buf_load,
   input wire ixm_pkg::ixm_word_t buf_wdata,
   input wire ixm_pkg::ixm_word_t buf_q,
   input wire logic               busy,
   input wire logic               done
);
   import ixm_pkg::*;
   logic [6:0] gap_r;
   logic       seen_r;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   // Cycles since last strobe; saturates so a long idle never wraps
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         gap_r  <= 7'h00;
         seen_r <= 1'b0;
      end else if (strobe) begin
         gap_r  <= 7'h01;
         seen_r <= 1'b1;
      end else if (gap_r != 7'h7f) begin
         gap_r <= gap_r + 7'h01;
      end
   end

   chk_access_delay: assert property (start |-> ##15 strobe)
      else $error("strobe not 15 cycles after start");
   chk_done_delay: assert property (strobe |-> ##75 done)
      else $error("done not 75 cycles after strobe");
   chk_strobe_gap: assert property (
      strobe && seen_r |-> gap_r >= 7'h5a)
      else $error("strobes closer than 90 cycles");
   chk_start_idle: assert property (start |-> !busy)
      else $error("start issued while busy");
   chk_addr_held: assert property (strobe |-> $stable(addr))
      else $error("address moved at strobe");
   chk_cw_keeps: assert property (
      strobe && cyc_type == IXM_CYC_CW |=> $stable(buf_q))
      else $error("clear-write strobe changed buffer");
   chk_buf_load: assert property (buf_load && !strobe |=>
      buf_q == $past(buf_wdata)) else $error("buffer load lost");
   chk_busy_span: assert property (strobe |-> busy[*8])
      else $error("busy dropped after strobe");
   chk_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");

   cov_rw: cover property (strobe && cyc_type == IXM_CYC_RW);
   cov_ro: cover property (strobe && cyc_type == IXM_CYC_RO);
   cov_cw: cover property (strobe && cyc_type == IXM_CYC_CW);
endmodule

// ### tb.sv
// Bench: sequencer and index memory joined end to end, scoreboarded
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
   end end
module tb;
   import ixm_pkg::*;
   typedef struct {ixm_word_t word; logic par; logic use_par;} ixm_note_t;
   logic       core_clk_in = 1'b0;
   logic       rst_b_in    = 1'b0;
   logic       req_in      = 1'b0;
   ixm_cyc_t   req_type_in = IXM_CYC_RW;
   ixm_addr_t  req_addr_in = 6'h00;
   ixm_word_t  wr_data_in  = 19'h00000;
   logic       ready_out, done_out, busy_out, parity_ok_out;
   ixm_word_t  rd_data_out;
   ixm_word_t  mem_m [64];
   ixm_note_t  notes_q [$];
   ixm_note_t  mn;
   int         error_cnt   = 0;
   int         check_count = 0;
   integer     seed        = 79;

   ixm_if link ();
   ixm_ctl ixm_ctl_i (.core_clk_in, .rst_b_in, .req_in, .req_type_in,
      .req_addr_in, .wr_data_in, .ready_out, .done_out, .rd_data_out,
      .mem(link));
   ixm_dev ixm_dev_i (.core_clk_in, .rst_b_in, .busy_out, .parity_ok_out,
      .mem(link));
   ixm_assertions ixm_assertions_i (.core_clk_in, .rst_b_in,
      .addr(link.addr), .cyc_type(link.cyc_type), .start(link.start),
      .strobe(link.strobe), .buf_load(link.buf_load),
      .buf_wdata(link.buf_wdata), .buf_q(link.buf_q), .busy(link.busy),
      .done(link.done));

   // 25 MHz core clock
   always #20 core_clk_in = ~core_clk_in;

   task final_report();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Word with even parity over all 19 bits, bad flips the parity bit
   function automatic ixm_word_t mk(input logic [17:0] v, input logic bad);
      return {(^v) ^ bad, v};
   endfunction

   // One cycle: note expectation, request, spam refused requests, wait
   task automatic do_op(input ixm_cyc_t t, input ixm_addr_t a,
                        input ixm_word_t d);
      ixm_note_t n;
      int        i;
      n.word    = (t == IXM_CYC_CW) ? d : mem_m[a];
      n.par     = ~^n.word;
      n.use_par = (t != IXM_CYC_CW);
      notes_q.push_back(n);
      if (t == IXM_CYC_RO) mem_m[a] = 19'h00000;
      if (t == IXM_CYC_CW) mem_m[a] = d;
      @(posedge core_clk_in);
      req_in      <= 1'b1;
      req_type_in <= t;
      req_addr_in <= a;
      wr_data_in  <= d;
      @(posedge core_clk_in);
      req_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      `CHK(busy_out, 1'b1)
      `CHK(ready_out, 1'b0)
      // Requests while busy must be ignored
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk_in);
         req_in      <= 1'($random(seed));
         req_addr_in <= 6'($random(seed));
      end
      @(posedge core_clk_in);
      req_in <= 1'b0;
      for (i = 0; i < 200 && done_out !== 1'b1; i++) @(posedge core_clk_in);
      if (i == 200) begin
         error_cnt++;
         final_report();
      end
   endtask

   // Result watcher: oldest note against each finished cycle
   always @(posedge core_clk_in) begin
      if (done_out === 1'b1) begin
         if (notes_q.size() == 0) `CHK(1'b1, 1'b0)
         else begin
            mn = notes_q.pop_front();
            `CHK(rd_data_out, mn.word)
            if (mn.use_par) `CHK(parity_ok_out, mn.par)
            `CHK(ready_out, 1'b1)
            `CHK(busy_out, 1'b0)
         end
      end
   end

   // Main sequence
   initial begin
      foreach (mem_m[k]) mem_m[k] = 19'h00000;
      repeat (10) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      @(posedge core_clk_in);
      `CHK(ready_out, 1'b1)
      // Both words of one pair, then read them apart
      do_op(IXM_CYC_CW, 6'h05, mk(18'h2a5c3, 1'b0));
      do_op(IXM_CYC_CW, 6'h25, mk(18'h15a3c, 1'b1));
      do_op(IXM_CYC_RW, 6'h05, 19'h00000);
      do_op(IXM_CYC_RO, 6'h25, 19'h00000);
      do_op(IXM_CYC_RO, 6'h25, 19'h00000);
      // Random mix of all three cycle kinds over a few pairs
      repeat (30) do_op(ixm_cyc_t'($unsigned($random(seed)) % 3),
         6'($random(seed)) & 6'h27,
         mk(18'($random(seed)), ($random(seed) & 7) == 0));
      // Every word read out once
      for (int a = 0; a < 64; a++) do_op(IXM_CYC_RO, 6'(a), 19'h0);
      repeat (3) @(posedge core_clk_in);
      `CHK(notes_q.size(), 0)
      final_report();
   end
endmodule
